//--- src/lslm_pkg.sv
// constants, field layouts and carrier types for the line signal-loss and lock monitor
package lslm_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [15:0] CTRL_OFFSET   = 16'h0383;
	localparam logic [15:0] STATUS_OFFSET = 16'h0384;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  RDATA_RESET   = 8'h00;

	// control field positions
	localparam int CTRL_SYNTH_EN_BIT  = 0;
	localparam int CTRL_IN_SEL_LSB    = 1;
	localparam int CTRL_OUT_RATE_LSB  = 3;
	localparam int CTRL_TX_SRC_BIT    = 5;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h3F;

	// status field positions
	localparam int STAT_P_LOSS_BIT   = 0;
	localparam int STAT_R_LOSS_BIT   = 1;
	localparam int STAT_OUT_LOCK_BIT = 2;
	localparam int STAT_P_POL_BIT    = 3;
	localparam int STAT_R_POL_BIT    = 4;
	localparam int STAT_STRAP_BIT    = 5;

	// ---------------------------------------------------------------
	// synchroniser lanes
	// ---------------------------------------------------------------
	localparam int SYNC_LANES   = 6;
	localparam int IDX_P_LOGIC  = 0;
	localparam int IDX_P_DIFF   = 1;
	localparam int IDX_R_LOGIC  = 2;
	localparam int IDX_R_DIFF   = 3;
	localparam int IDX_REF_CLK  = 4;
	localparam int IDX_REC_CLK  = 5;

	// ---------------------------------------------------------------
	// timing and counts
	// ---------------------------------------------------------------
	localparam int          STRAP_SETTLE_CYCLES = 4;
	localparam int          LOCK_WINDOW_EDGES   = 4096;
	localparam int          LOCK_TOL_PPM        = 500;
	localparam int          CNT_W               = 16;
	localparam logic [15:0] CNT_RESET           = 16'h0000;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		LSLM_IN_19M44,
		LSLM_IN_38M88,
		LSLM_IN_51M84,
		LSLM_IN_77M76
	} lslm_in_sel_t;

	typedef struct packed {
		logic [1:0]   reserved;
		logic         tx_clk_from_synth;
		logic [1:0]   out_rate;
		lslm_in_sel_t in_sel;
		logic         synth_en;
	} lslm_ctrl_t;

	typedef struct packed {
		logic carrier_loss;
		logic loss_detect;
		logic signal_loss_defect;
	} lslm_port_stat_t;

endpackage : lslm_pkg

//--- src/lslm_sync_edge.sv
// two-flop synchroniser with a rising-edge pulse for one asynchronous lane
`timescale 1ns/1ps
module lslm_sync_edge (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// asynchronous input
	input  wire logic async_in,
	// synchronised results
	output logic      level_q,
	output logic      rise_q
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// ---------------------------------------------------------------
	// synchroniser
	// ---------------------------------------------------------------
	// meta_q feeds only sync_q; everything else looks at sync_q onward
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	// ---------------------------------------------------------------
	// edge detect
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prev_q  <= 1'b0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
		end else begin
			prev_q  <= sync_q;
			level_q <= sync_q;
			rise_q  <= sync_q & ~prev_q;
		end
	end

endmodule : lslm_sync_edge

//--- src/lslm_top.sv
// line signal-loss qualification, clock-recovery lock check and synthesizer control
//
// Functional notes
// - primary logic loss polarity from differential pin strap
// - redundant logic loss polarity from differential strap
// - differential loss polarity from same-port logic strap
// - true loss raises carrier loss and loss-detect
// - signal-loss defect only from own detection
// - lock while recovered/reference difference under 0.05%
// - lock indicator low locked, high unlocked
`timescale 1ns/1ps
module lslm_top #(
	parameter int LOCK_WINDOW = lslm_pkg::LOCK_WINDOW_EDGES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// host register port
	input  wire logic [15:0] host_addr,
	input  wire logic        host_wr,
	input  wire logic        host_rd,
	input  wire logic [7:0]  host_wdata,
	output logic      [7:0]  host_rdata,
	output logic             host_rvalid,
	// loss pins from the transceivers
	input  wire logic        primary_loss_logic_input,
	input  wire logic        primary_loss_diff_input,
	input  wire logic        redundant_loss_logic_input,
	input  wire logic        redundant_loss_diff_input,
	input  wire logic        primary_use_diff,
	input  wire logic        redundant_use_diff,
	// receiver own signal-loss detection
	input  wire logic        primary_own_signal_loss,
	input  wire logic        redundant_own_signal_loss,
	// clocks compared for lock
	input  wire logic        synth_reference_clock_input,
	input  wire logic        recovered_clock_19m,
	// loss and lock indications
	output logic             primary_carrier_loss,
	output logic             primary_carrier_loss_detect_flag,
	output logic             primary_signal_loss_defect,
	output logic             redundant_carrier_loss,
	output logic             redundant_carrier_loss_detect_flag,
	output logic             redundant_signal_loss_defect,
	output logic             recovery_lock_indicator,
	// synthesizer configuration
	output logic             synth_enable,
	output logic      [1:0]  synth_input_select,
	output logic      [1:0]  synth_output_rate,
	output logic             tx_clock_from_synth
);

	localparam logic [15:0] WINDOW_EDGES = 16'(LOCK_WINDOW);
	localparam logic [15:0] TOL_EDGES    = 16'((LOCK_WINDOW * lslm_pkg::LOCK_TOL_PPM) / 1000000);
	localparam logic [2:0]  SETTLE       = 3'(lslm_pkg::STRAP_SETTLE_CYCLES);

	logic [lslm_pkg::SYNC_LANES-1:0] async_vec;
	logic [lslm_pkg::SYNC_LANES-1:0] lvl;
	logic [lslm_pkg::SYNC_LANES-1:0] rise;
	lslm_pkg::lslm_ctrl_t            ctrl_q;
	logic [2:0]                      settle_q;
	logic                            strap_done_q;
	logic                            p_pol_q;
	logic                            r_pol_q;
	logic                            p_loss_d;
	logic                            r_loss_d;
	logic [15:0]                     ref_cnt_q;
	logic [15:0]                     rec_cnt_q;
	logic [15:0]                     rec_diff;
	logic                            out_of_lock_q;
	logic [7:0]                      status_vec;

	// ---------------------------------------------------------------
	// synchronisers
	// ---------------------------------------------------------------
	assign async_vec = {recovered_clock_19m, synth_reference_clock_input,
		redundant_loss_diff_input, redundant_loss_logic_input,
		primary_loss_diff_input, primary_loss_logic_input};

	generate
		for (genvar i = 0; i < lslm_pkg::SYNC_LANES; i++) begin : g_sync
			lslm_sync_edge u_sync (
				.clk_sys  (clk_sys),
				.reset_n  (reset_n),
				.async_in (async_vec[i]),
				.level_q  (lvl[i]),
				.rise_q   (rise[i])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// strap capture
	// ---------------------------------------------------------------
	// straps are caught once the synchroniser has flushed after release;
	// the idle pin of each pair is the strap, the other carries loss
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			settle_q     <= 3'h0;
			strap_done_q <= 1'b0;
			p_pol_q      <= 1'b0;
			r_pol_q      <= 1'b0;
		end else if (!strap_done_q) begin
			if (settle_q == SETTLE) begin
				strap_done_q <= 1'b1;
				p_pol_q      <= primary_use_diff ? lvl[lslm_pkg::IDX_P_LOGIC]
					: lvl[lslm_pkg::IDX_P_DIFF];
				r_pol_q      <= redundant_use_diff ? lvl[lslm_pkg::IDX_R_LOGIC]
					: lvl[lslm_pkg::IDX_R_DIFF];
			end else begin
				settle_q <= settle_q + 3'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// loss qualification
	// ---------------------------------------------------------------
	// polarity 1 means active-high, 0 active-low
	always_comb begin
		p_loss_d = 1'b0;
		r_loss_d = 1'b0;
		if (strap_done_q) begin
			p_loss_d = (primary_use_diff ? lvl[lslm_pkg::IDX_P_DIFF]
				: lvl[lslm_pkg::IDX_P_LOGIC]) == p_pol_q;
			r_loss_d = (redundant_use_diff ? lvl[lslm_pkg::IDX_R_DIFF]
				: lvl[lslm_pkg::IDX_R_LOGIC]) == r_pol_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			primary_carrier_loss               <= 1'b0;
			primary_carrier_loss_detect_flag   <= 1'b0;
			redundant_carrier_loss             <= 1'b0;
			redundant_carrier_loss_detect_flag <= 1'b0;
		end else begin
			primary_carrier_loss               <= p_loss_d;
			primary_carrier_loss_detect_flag   <= p_loss_d;
			redundant_carrier_loss             <= r_loss_d;
			redundant_carrier_loss_detect_flag <= r_loss_d;
		end
	end

	// the external pin never feeds the defect; only the receiver's own view does
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			primary_signal_loss_defect   <= 1'b0;
			redundant_signal_loss_defect <= 1'b0;
		end else begin
			primary_signal_loss_defect   <= primary_own_signal_loss;
			redundant_signal_loss_defect <= redundant_own_signal_loss;
		end
	end

	// ---------------------------------------------------------------
	// lock check
	// ---------------------------------------------------------------
	// a window of reference edges against recovered edges; the window is long
	// enough that the 0.05% band spans at least a couple of edges
	assign rec_diff = (rec_cnt_q > WINDOW_EDGES) ? rec_cnt_q - WINDOW_EDGES
		: WINDOW_EDGES - rec_cnt_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ref_cnt_q     <= lslm_pkg::CNT_RESET;
			rec_cnt_q     <= lslm_pkg::CNT_RESET;
			out_of_lock_q <= 1'b1;
		end else if (rise[lslm_pkg::IDX_REF_CLK] && ref_cnt_q == WINDOW_EDGES - 16'h1) begin
			ref_cnt_q     <= lslm_pkg::CNT_RESET;
			rec_cnt_q     <= {15'h0, rise[lslm_pkg::IDX_REC_CLK]};
			out_of_lock_q <= rec_diff > TOL_EDGES;
		end else begin
			if (rise[lslm_pkg::IDX_REF_CLK])
				ref_cnt_q <= ref_cnt_q + 16'h1;
			if (rise[lslm_pkg::IDX_REC_CLK] && rec_cnt_q != 16'hFFFF)
				rec_cnt_q <= rec_cnt_q + 16'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			recovery_lock_indicator <= 1'b1;
		else
			recovery_lock_indicator <= out_of_lock_q;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// register timing does not need the reference clock; without it the lock
	// window never closes and status stays stale
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			ctrl_q <= lslm_pkg::lslm_ctrl_t'(lslm_pkg::CTRL_RESET);
		else if (host_wr && host_addr == lslm_pkg::CTRL_OFFSET)
			ctrl_q <= lslm_pkg::lslm_ctrl_t'(host_wdata & lslm_pkg::CTRL_WRITE_MASK);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			synth_enable        <= 1'b0;
			synth_input_select  <= 2'h0;
			synth_output_rate   <= 2'h0;
			tx_clock_from_synth <= 1'b0;
		end else begin
			synth_enable        <= ctrl_q.synth_en;
			synth_input_select  <= ctrl_q.in_sel;
			synth_output_rate   <= ctrl_q.out_rate;
			tx_clock_from_synth <= ctrl_q.tx_clk_from_synth & ctrl_q.synth_en;
		end
	end

	always_comb begin
		status_vec = 8'h00;
		status_vec[lslm_pkg::STAT_P_LOSS_BIT]   = primary_carrier_loss;
		status_vec[lslm_pkg::STAT_R_LOSS_BIT]   = redundant_carrier_loss;
		status_vec[lslm_pkg::STAT_OUT_LOCK_BIT] = out_of_lock_q;
		status_vec[lslm_pkg::STAT_P_POL_BIT]    = p_pol_q;
		status_vec[lslm_pkg::STAT_R_POL_BIT]    = r_pol_q;
		status_vec[lslm_pkg::STAT_STRAP_BIT]    = strap_done_q;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			host_rdata  <= lslm_pkg::RDATA_RESET;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			if (host_rd) begin
				if (host_addr == lslm_pkg::CTRL_OFFSET)
					host_rdata <= ctrl_q;
				else if (host_addr == lslm_pkg::STATUS_OFFSET)
					host_rdata <= status_vec;
				else
					host_rdata <= 8'h00;
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_ctrl_write;
		host_wr && host_addr == lslm_pkg::CTRL_OFFSET;
	endsequence

	sequence s_cfg_visible;
		##2 synth_enable == $past(host_wdata[0], 2);
	endsequence

	p_loss_follows_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		primary_carrier_loss == $past(p_loss_d) && primary_carrier_loss_detect_flag == $past(p_loss_d))
		else $error("primary loss flags disagree");

	r_loss_follows_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(r_loss_d) == redundant_carrier_loss_detect_flag)
		else $error("redundant loss-detect late or wrong");

	p_pol_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		strap_done_q && !primary_use_diff && lvl[lslm_pkg::IDX_P_LOGIC] == p_pol_q
		|=> primary_carrier_loss)
		else $error("primary logic loss not declared");

	r_pol_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		strap_done_q && !redundant_use_diff && lvl[lslm_pkg::IDX_R_LOGIC] != r_pol_q
		|=> !redundant_carrier_loss)
		else $error("redundant loss declared while idle");

	diff_pol_apply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		strap_done_q && primary_use_diff && lvl[lslm_pkg::IDX_P_DIFF] == p_pol_q
		|=> primary_carrier_loss_detect_flag)
		else $error("differential loss not declared");

	defect_own_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!primary_own_signal_loss |=> !primary_signal_loss_defect)
		else $error("defect raised without own detection");

	lock_pin_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$changed(out_of_lock_q) |=> recovery_lock_indicator == $past(out_of_lock_q))
		else $error("lock indicator does not follow lock state");

	lock_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!(rise[lslm_pkg::IDX_REF_CLK] && ref_cnt_q == WINDOW_EDGES - 16'h1)
		|=> $stable(out_of_lock_q))
		else $error("lock state moved outside window end");

	ctrl_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_ctrl_write |-> s_cfg_visible)
		else $error("synthesizer enable not updated by write");

	strap_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!strap_done_q |-> !primary_carrier_loss && !redundant_carrier_loss)
		else $error("loss declared before straps settled");

endmodule : lslm_top

//--- verification/lslm_line_partner.sv
// transceiver loss pins and reference/recovered clock sources facing the monitor
`timescale 1ns/1ps
module lslm_line_partner #(
	parameter real REF_HALF_NS = 25.72,
	parameter real REC_SKEW_NS = 0.26
) (
	// line state requested by the bench, [0] primary, [1] redundant
	input  wire logic       rec_fast,
	input  wire logic [1:0] use_diff,
	input  wire logic [1:0] pol_high,
	input  wire logic [1:0] loss,
	// pins toward the monitor
	output logic            ref_clk,
	output logic            rec_clk,
	output logic [1:0]      loss_logic,
	output logic [1:0]      loss_diff
);
	// ---------------------------------------------------------------
	// clocks
	// ---------------------------------------------------------------
	// reference runs free at 19.44 MHz, also across register accesses
	initial begin
		ref_clk = 1'b0;
		forever #(REF_HALF_NS) ref_clk = ~ref_clk;
	end
	// recovered clock has its own phase; fast mode is about 1% off
	initial begin
		rec_clk = 1'b0;
		#7;
		forever #(rec_fast ? REF_HALF_NS - REC_SKEW_NS : REF_HALF_NS) rec_clk = ~rec_clk;
	end

	// ---------------------------------------------------------------
	// loss pins: the unused pin of a port is tied to its strap level
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			loss_logic[i] = use_diff[i] ? pol_high[i] : ~(loss[i] ^ pol_high[i]);
			loss_diff[i]  = use_diff[i] ? ~(loss[i] ^ pol_high[i]) : pol_high[i];
		end
	end
endmodule : lslm_line_partner

//--- verification/tb.sv
// self-checking bench for the line signal-loss and lock monitor
`timescale 1ns/1ps
module tb;
	logic        clk_sys;
	logic        reset_n;
	logic [15:0] host_addr;
	logic        host_wr;
	logic        host_rd;
	logic [7:0]  host_wdata;
	logic [7:0]  host_rdata;
	logic        host_rvalid;
	logic        rec_fast;
	logic [1:0]  use_diff;
	logic [1:0]  pol_high;
	logic [1:0]  loss;
	logic [1:0]  own_loss;
	logic        ref_clk;
	logic        rec_clk;
	logic [1:0]  loss_logic;
	logic [1:0]  loss_diff;
	logic        p_cl, p_fl, p_df, r_cl, r_fl, r_df, lock_n;
	logic        s_en, tx_src;
	logic [1:0]  s_sel, s_rate;
	int          mismatches;
	int          n_compared;

	lslm_line_partner lslm_line_partner_i (.rec_fast(rec_fast), .use_diff(use_diff),
		.pol_high(pol_high), .loss(loss), .ref_clk(ref_clk), .rec_clk(rec_clk),
		.loss_logic(loss_logic), .loss_diff(loss_diff));

	lslm_top #(.LOCK_WINDOW(2048)) lslm_top_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.primary_loss_logic_input(loss_logic[0]), .primary_loss_diff_input(loss_diff[0]),
		.redundant_loss_logic_input(loss_logic[1]),
		.redundant_loss_diff_input(loss_diff[1]),
		.primary_use_diff(use_diff[0]), .redundant_use_diff(use_diff[1]),
		.primary_own_signal_loss(own_loss[0]), .redundant_own_signal_loss(own_loss[1]),
		.synth_reference_clock_input(ref_clk), .recovered_clock_19m(rec_clk),
		.primary_carrier_loss(p_cl), .primary_carrier_loss_detect_flag(p_fl),
		.primary_signal_loss_defect(p_df), .redundant_carrier_loss(r_cl),
		.redundant_carrier_loss_detect_flag(r_fl), .redundant_signal_loss_defect(r_df),
		.recovery_lock_indicator(lock_n), .synth_enable(s_en),
		.synth_input_select(s_sel), .synth_output_rate(s_rate),
		.tx_clock_from_synth(tx_src));

	initial begin
		clk_sys = 1'b0;
	end
	always #5 clk_sys = ~clk_sys;

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : chk

	task automatic do_reset;
		reset_n = 1'b0;
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		// straps are captured a few edges after release
		repeat (10) @(negedge clk_sys);
	endtask : do_reset

	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge clk_sys);
		host_wr = 1'b0;
		@(negedge clk_sys);
	endtask : reg_wr

	task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp, input string what);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge clk_sys);
		host_rd = 1'b0;
		chk("read valid", 8'h01, {7'h00, host_rvalid});
		chk(what, exp, host_rdata);
		// let an edge pass so a following read does not rewrite the strobe at once
		@(negedge clk_sys);
	endtask : reg_rd

	task automatic chk_ports(input string what, input logic ep, input logic er);
		chk(what, {4'h0, ep, ep, er, er}, {4'h0, p_cl, p_fl, r_cl, r_fl});
	endtask : chk_ports

	task automatic wait_lock(input logic v);
		int n;
		n = 0;
		while (lock_n !== v && n < 40000) begin
			@(negedge clk_sys);
			n++;
		end
		chk("lock indicator", {7'h00, v}, {7'h00, lock_n});
	endtask : wait_lock

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	initial begin
		#500_000;
		mismatches++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] d;
		mismatches = 0;
		n_compared = 0;
		reset_n = 1'b0;
		host_addr = 16'h0000;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 8'h00;
		rec_fast = 1'b0;
		use_diff = 2'h0;
		pol_high = 2'h0;
		loss = 2'h0;
		own_loss = 2'h0;
		do_reset();
		chk("lock after reset", 8'h01, {7'h00, lock_n});
		reg_rd(lslm_pkg::CTRL_OFFSET, lslm_pkg::CTRL_RESET, "ctrl reset");
		reg_wr(lslm_pkg::CTRL_OFFSET, 8'hFF);
		chk("cfg all ones", 8'h3F, {2'h0, tx_src, s_rate, s_sel, s_en});
		reg_rd(lslm_pkg::CTRL_OFFSET, 8'h3F, "ctrl masked");
		for (int s = 0; s < 4; s++) begin
			d = 8'h21 | 8'(s << 1) | 8'(s << 3);
			reg_wr(lslm_pkg::CTRL_OFFSET, d);
			chk("cfg select", {4'h0, 2'(s), 2'(s)}, {4'h0, s_rate, s_sel});
			chk("cfg enable", 8'h03, {6'h00, tx_src, s_en});
		end
		reg_wr(lslm_pkg::CTRL_OFFSET, 8'h20);
		chk("synth off", 8'h00, {6'h00, tx_src, s_en});
		reg_wr(16'h0385, 8'h15);
		reg_rd(lslm_pkg::CTRL_OFFSET, 8'h20, "ctrl after stray write");
		reg_rd(16'h0100, 8'h00, "unmapped read");

		// every strap polarity and pin choice, both ports at once
		for (int k = 0; k < 4; k++) begin
			use_diff = {~k[0], k[0]};
			pol_high = {~k[1], k[1]};
			loss = 2'h0;
			own_loss = 2'h0;
			do_reset();
			chk_ports("idle loss", 1'b0, 1'b0);
			d = {2'h0, 1'b1, pol_high, 3'h4};
			reg_rd(lslm_pkg::STATUS_OFFSET, d, "status idle");
			loss[0] = 1'b1;
			repeat (3) @(negedge clk_sys);
			chk_ports("primary loss early", 1'b0, 1'b0);
			@(negedge clk_sys);
			chk_ports("primary loss", 1'b1, 1'b0);
			loss[1] = 1'b1;
			repeat (4) @(negedge clk_sys);
			chk_ports("both loss", 1'b1, 1'b1);
			chk("defect from pins", 8'h00, {6'h00, r_df, p_df});
			reg_rd(lslm_pkg::STATUS_OFFSET, d | 8'h03, "status loss");
			own_loss = 2'h3;
			@(negedge clk_sys);
			chk("own defect", 8'h03, {6'h00, r_df, p_df});
			loss = 2'h0;
			own_loss = 2'h0;
			repeat (4) @(negedge clk_sys);
			chk_ports("loss cleared", 1'b0, 1'b0);
		end

		// equal clocks lock, skewed clocks lose lock
		wait_lock(1'b0);
		reg_rd(lslm_pkg::STATUS_OFFSET, 8'h20 | {3'h0, pol_high, 3'h0}, "status locked");
		rec_fast = 1'b1;
		wait_lock(1'b1);
		finish_test();
	end
endmodule : tb
